// ==== rtl/adcc_pkg.sv ====
package adcc_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] ADCC_OFS_START    = 12'h0_000;
  localparam logic [11:0] ADCC_OFS_STOP     = 12'h0_004;
  localparam logic [11:0] ADCC_OFS_DONE     = 12'h0_100;
  localparam logic [11:0] ADCC_OFS_IRQ_SET  = 12'h0_304;
  localparam logic [11:0] ADCC_OFS_IRQ_CLR  = 12'h0_308;
  localparam logic [11:0] ADCC_OFS_BUSY     = 12'h0_400;
  localparam logic [11:0] ADCC_OFS_ENABLE   = 12'h0_500;
  localparam logic [11:0] ADCC_OFS_CONFIG   = 12'h0_504;
  localparam logic [11:0] ADCC_OFS_RESULT   = 12'h0_508;

  // ----------------------------------------
  // config field layout
  // ----------------------------------------
  localparam int          ADCC_RES_LSB      = 0;
  localparam int          ADCC_INP_LSB      = 2;
  localparam int          ADCC_REF_LSB      = 5;
  localparam int          ADCC_PSEL_LSB     = 8;
  localparam int          ADCC_EXT_LSB      = 16;
  localparam logic [31:0] ADCC_CONFIG_MASK  = 32'h0003_FF7F;
  localparam logic [31:0] ADCC_CONFIG_RESET = 32'h0000_0000;
  localparam logic [1:0]  ADCC_RES_8        = 2'h0;
  localparam logic [1:0]  ADCC_RES_9        = 2'h1;
  localparam logic [1:0]  ADCC_RES_10       = 2'h2;
  localparam logic [2:0]  ADCC_INP_PIN      = 3'h0;
  localparam logic [2:0]  ADCC_INP_PIN_2_3  = 3'h1;
  localparam logic [2:0]  ADCC_INP_PIN_1_3  = 3'h2;
  localparam logic [2:0]  ADCC_INP_VDD_2_3  = 3'h5;
  localparam logic [2:0]  ADCC_INP_VDD_1_3  = 3'h6;
  localparam logic [1:0]  ADCC_REF_EXT      = 2'h1;
  localparam logic [1:0]  ADCC_ENABLE_RESET = 2'h0;
  localparam logic [1:0]  ADCC_ENABLE_ON    = 2'h1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          ADCC_CLK_HZ       = 10_000_000;
  localparam int          ADCC_CONV_NS      = 20_000;
  localparam int          ADCC_CONV_CYC     = (ADCC_CONV_NS * (ADCC_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0]  ADCC_CONV_CNT     = 8'(ADCC_CONV_CYC);

endpackage

// ==== rtl/adcc_conv_seq.sv ====
`timescale 1ns/100ps
module adcc_conv_seq (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [9:0] sample,
  input  wire logic [1:0] res,
  output logic            busy,
  output logic            done,
  output logic [9:0]      value
);
  import adcc_pkg::*;

  typedef enum logic [0:0] {ADCC_IDLE, ADCC_CONV} adcc_state_e;

  adcc_state_e state_reg;
  logic [7:0]  cnt_reg;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ADCC_IDLE;
      cnt_reg   <= 8'h00;
      done      <= 1'b0;
      value     <= 10'h000;
    end else begin
      done <= 1'b0;
      case (state_reg)
        ADCC_IDLE: begin
          if (start && !stop) begin
            state_reg <= ADCC_CONV;
            cnt_reg   <= ADCC_CONV_CNT;
          end
        end
        ADCC_CONV: begin
          if (stop) begin
            state_reg <= ADCC_IDLE;
          end else if (cnt_reg == 8'h01) begin
            state_reg <= ADCC_IDLE;
            done      <= 1'b1;
            case (res)
              ADCC_RES_8: value <= {2'b00, sample[9:2]};
              ADCC_RES_9: value <= {1'b0, sample[9:1]};
              default:    value <= sample;
            endcase
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= ADCC_IDLE;
      endcase
    end
  end

  assign busy = (state_reg == ADCC_CONV);

endmodule

// ==== rtl/adcc_top.sv ====
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
module adcc_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        start_event,
  input  wire logic [9:0]  sample_data,
  output logic             analog_power_req,
  output logic [7:0]       analog_pin_claim,
  output logic [1:0]       ref_pin_claim,
  output logic [2:0]       input_source_select,
  output logic [1:0]       reference_select,
  output logic [1:0]       resolution,
  output logic             done_pulse,
  output logic             irq
);
  import adcc_pkg::*;

  logic [31:0] config_reg;
  logic [1:0]  enable_reg;
  logic        done_evt_reg;
  logic        irq_en_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic        busy;
  logic        seq_done;
  logic [9:0]  seq_value;
  logic        wr_fire;
  logic        rd_fire;
  logic        start_cmd;
  logic        stop_cmd;
  logic [31:0] rd_next;

  function automatic logic is_addr(input logic [31:0] a, input logic [11:0] ofs);
    is_addr = (a[11:0] == ofs);
  endfunction

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign wr_fire   = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign start_cmd = start_event || (wr_fire && is_addr(aw_addr_reg, ADCC_OFS_START) && w_data_reg[0]);
  assign stop_cmd  = wr_fire && is_addr(aw_addr_reg, ADCC_OFS_STOP) && w_data_reg[0];

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 32'h0000_0000;
      w_data_reg    <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {20'h0_0000, s_axi_awaddr};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (is_addr(aw_addr_reg, ADCC_OFS_START) || is_addr(aw_addr_reg, ADCC_OFS_STOP) ||
                         is_addr(aw_addr_reg, ADCC_OFS_DONE) || is_addr(aw_addr_reg, ADCC_OFS_IRQ_SET) ||
                         is_addr(aw_addr_reg, ADCC_OFS_IRQ_CLR) || is_addr(aw_addr_reg, ADCC_OFS_ENABLE) ||
                         is_addr(aw_addr_reg, ADCC_OFS_CONFIG)) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      config_reg <= ADCC_CONFIG_RESET;
      enable_reg <= ADCC_ENABLE_RESET;
      irq_en_reg <= 1'b0;
    end else if (wr_fire) begin
      if (is_addr(aw_addr_reg, ADCC_OFS_CONFIG) && !busy) begin
        config_reg <= w_data_reg & ADCC_CONFIG_MASK;
      end
      if (is_addr(aw_addr_reg, ADCC_OFS_ENABLE)) begin
        enable_reg <= w_data_reg[1:0];
      end
      if (is_addr(aw_addr_reg, ADCC_OFS_IRQ_SET) && w_data_reg[0]) begin
        irq_en_reg <= 1'b1;
      end else if (is_addr(aw_addr_reg, ADCC_OFS_IRQ_CLR) && w_data_reg[0]) begin
        irq_en_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // end event: set wins, read or write-0 clears
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      done_evt_reg <= 1'b0;
    end else if (seq_done) begin
      done_evt_reg <= 1'b1;
    end else if ((rd_fire && s_axi_araddr == ADCC_OFS_DONE) ||
                 (wr_fire && is_addr(aw_addr_reg, ADCC_OFS_DONE) && !w_data_reg[0])) begin
      done_evt_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_next = 32'h0000_0000;
    case (s_axi_araddr)
      ADCC_OFS_DONE:    rd_next = {31'h0000_0000, done_evt_reg};
      ADCC_OFS_IRQ_SET: rd_next = {31'h0000_0000, irq_en_reg};
      ADCC_OFS_IRQ_CLR: rd_next = {31'h0000_0000, irq_en_reg};
      ADCC_OFS_BUSY:    rd_next = {31'h0000_0000, busy};
      ADCC_OFS_ENABLE:  rd_next = {30'h0000_0000, enable_reg};
      ADCC_OFS_CONFIG:  rd_next = config_reg;
      ADCC_OFS_RESULT:  rd_next = {22'h00_0000, seq_value};
      default:          rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_next;
        s_axi_rresp  <= (s_axi_araddr == ADCC_OFS_DONE || s_axi_araddr == ADCC_OFS_IRQ_SET ||
                         s_axi_araddr == ADCC_OFS_IRQ_CLR || s_axi_araddr == ADCC_OFS_BUSY ||
                         s_axi_araddr == ADCC_OFS_ENABLE || s_axi_araddr == ADCC_OFS_CONFIG ||
                         s_axi_araddr == ADCC_OFS_RESULT) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  adcc_conv_seq u_seq (
    .clk   (clk),
    .reset (reset),
    .start (start_cmd),
    .stop  (stop_cmd),
    .sample(sample_data),
    .res   (config_reg[ADCC_RES_LSB +: 2]),
    .busy  (busy),
    .done  (seq_done),
    .value (seq_value)
  );

  // ----------------------------------------
  // pin ownership, power, interrupt outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      analog_power_req    <= 1'b0;
      analog_pin_claim    <= 8'h00;
      ref_pin_claim       <= 2'b00;
      input_source_select <= 3'h0;
      reference_select    <= 2'h0;
      resolution          <= 2'h0;
      done_pulse          <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      // power follows busy: drops on finish or stop
      analog_power_req    <= busy && !seq_done && !stop_cmd;
      analog_pin_claim    <= (enable_reg != 2'b00) ? config_reg[ADCC_PSEL_LSB +: 8] : 8'h00;
      ref_pin_claim       <= (enable_reg != 2'b00 && config_reg[ADCC_REF_LSB +: 2] == ADCC_REF_EXT) ?
                             config_reg[ADCC_EXT_LSB +: 2] : 2'b00;
      input_source_select <= config_reg[ADCC_INP_LSB +: 3];
      reference_select    <= config_reg[ADCC_REF_LSB +: 2];
      resolution          <= config_reg[ADCC_RES_LSB +: 2];
      done_pulse          <= seq_done;
      irq                 <= (done_evt_reg || seq_done) && irq_en_reg;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_started;
    !busy ##1 busy;
  endsequence

  property p_start_busy;
    @(posedge clk) disable iff (reset) (start_cmd && !stop_cmd && !busy) |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

  property p_busy_len;
    @(posedge clk) disable iff (reset) s_started |-> busy [*8] ##0 (busy || stop_cmd || $past(stop_cmd));
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("conversion ended early");

  property p_done_event;
    @(posedge clk) disable iff (reset) seq_done |=> done_evt_reg && done_pulse;
  endproperty
  a_done_event: assert property (p_done_event) else $error("end event not raised");

  property p_done_ends_busy;
    @(posedge clk) disable iff (reset) seq_done |-> !busy && $past(busy);
  endproperty
  a_done_ends_busy: assert property (p_done_ends_busy) else $error("done without busy end");

  property p_power_off;
    @(posedge clk) disable iff (reset) $fell(busy) |=> !analog_power_req;
  endproperty
  a_power_off: assert property (p_power_off) else $error("power request stayed up");

  property p_stop_abort;
    @(posedge clk) disable iff (reset) (stop_cmd && busy) |=> !busy && !seq_done;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");

  property p_irq;
    @(posedge clk) disable iff (reset) (done_evt_reg && irq_en_reg) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_pin_release;
    @(posedge clk) disable iff (reset) (enable_reg == 2'b00) |=> analog_pin_claim == 8'h00;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pins held while disabled");

  property p_config_hold;
    @(posedge clk) disable iff (reset) busy |=> $stable(config_reg);
  endproperty
  a_config_hold: assert property (p_config_hold) else $error("config changed while busy");

  // finishing takes two steps: busy ends, then the event is flagged and power drops
  sequence s_finish;
    busy ##1 seq_done;
  endsequence

  property p_finish_steps;
    @(posedge clk) disable iff (reset) s_finish |=> done_evt_reg && !analog_power_req;
  endproperty
  a_finish_steps: assert property (p_finish_steps) else $error("finish did not flag and power down");

  property p_result_change;
    @(posedge clk) disable iff (reset) $changed(seq_value) |-> seq_done;
  endproperty
  a_result_change: assert property (p_result_change) else $error("result moved without completion");

  property p_no_restart;
    @(posedge clk) disable iff (reset) (!busy && !start_cmd) |=> !busy;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion began without start");

  property p_busy_read;
    @(posedge clk) disable iff (reset) (rd_fire && s_axi_araddr == ADCC_OFS_BUSY) |=> s_axi_rdata[0] == $past(busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy status read wrong");

  property p_claim_follow;
    @(posedge clk) disable iff (reset) (!wr_fire && enable_reg != 2'b00) |=>
      analog_pin_claim == config_reg[ADCC_PSEL_LSB +: 8];
  endproperty
  a_claim_follow: assert property (p_claim_follow) else $error("pin claim differs from select");

  property p_cfg_mirror;
    @(posedge clk) disable iff (reset) !wr_fire |=>
      resolution == config_reg[ADCC_RES_LSB +: 2] && input_source_select == config_reg[ADCC_INP_LSB +: 3];
  endproperty
  a_cfg_mirror: assert property (p_cfg_mirror) else $error("config fields not mirrored");

  property p_irq_mask;
    @(posedge clk) disable iff (reset) !irq_en_reg |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt raised while masked");

  property p_stop_power;
    @(posedge clk) disable iff (reset) (stop_cmd && busy) |=> !analog_power_req;
  endproperty
  a_stop_power: assert property (p_stop_power) else $error("stop left power request up");

endmodule

// ==== verification/adcc_front_model.sv ====
`timescale 1ns/100ps
module adcc_front_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       analog_power_req,
  input  wire logic [9:0] level,
  output logic      [9:0] sample_data
);
  // ----------------------------------------
  // front end sample output
  // ----------------------------------------
  // an unpowered front end toggles, so a stale sample never looks valid
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_data <= 10'h155;
    end else if (analog_power_req) begin
      sample_data <= level;
    end else begin
      sample_data <= ~sample_data;
    end
  end
endmodule

// ==== verification/adc_conversion_control_bench.sv ====
`timescale 1ns/100ps
module adc_conversion_control_bench;
  import adcc_pkg::*;
  logic        clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, start_event, analog_power_req, done_pulse, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, cfg, exp_res;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ref_pin_claim, reference_select, resolution, last_bresp;
  logic [9:0]  sample_data, level;
  logic [7:0]  analog_pin_claim;
  logic [2:0]  input_source_select;
  logic [45:0] exp_q[$];
  logic [45:0] mon_e;
  logic [2:0]  inp_codes [5] = '{ADCC_INP_PIN, ADCC_INP_PIN_2_3, ADCC_INP_PIN_1_3, ADCC_INP_VDD_2_3, ADCC_INP_VDD_1_3};
  int          fail_count, total_checks, seed, dn;

  adcc_top u_dut (
    .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .start_event(start_event), .sample_data(sample_data), .analog_power_req(analog_power_req),
    .analog_pin_claim(analog_pin_claim), .ref_pin_claim(ref_pin_claim),
    .input_source_select(input_source_select), .reference_select(reference_select),
    .resolution(resolution), .done_pulse(done_pulse), .irq(irq)
  );

  adcc_front_model u_front (
    .clk(clk), .reset(reset), .analog_power_req(analog_power_req), .level(level), .sample_data(sample_data)
  );

  // ----------------------------------------
  // clock, watchdog, shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #2_000_000;
    fail_count++;
    conclude();
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
    chk("write wait", 32'(n < 100), 32'h1);
  endtask

  // the expected read is noted first, the monitor compares it
  task automatic rd(input logic [11:0] a, input logic [1:0] rsp, input logic [31:0] d);
    int n;
    n = 0;
    exp_q.push_back({a, rsp, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    @(posedge clk);
    chk("read wait", 32'(n < 100), 32'h1);
  endtask

  always @(posedge clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      chk($sformatf("rdata at %h", mon_e[45:34]), s_axi_rdata, mon_e[31:0]);
      chk("rresp", 32'(s_axi_rresp), 32'(mon_e[33:32]));
    end
  end

  task automatic go(input bit evt);
    if (evt) begin
      start_event <= 1'b1;
      @(posedge clk);
      start_event <= 1'b0;
    end else begin
      wr(ADCC_OFS_START, 32'h0000_0001);
    end
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done_pulse !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("done wait", 32'(n < 400), 32'h1);
  endtask

  task automatic idle(input int c);
    dn = 0;
    repeat (c) begin
      @(posedge clk);
      dn += int'(done_pulse);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 48904;
    {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, start_event} = 7'h40;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, level} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(ADCC_OFS_BUSY, 2'h0, 32'h0);
    rd(ADCC_OFS_ENABLE, 2'h0, 32'h0);
    rd(ADCC_OFS_CONFIG, 2'h0, 32'h0);
    rd(ADCC_OFS_RESULT, 2'h0, 32'h0);
    rd(12'h00C, 2'h2, 32'h0);
    wr(ADCC_OFS_RESULT, 32'h0000_0001);
    chk("result write resp", 32'(last_bresp), 32'h2);
    $display("test reset values done");
    // no comparator or sibling peripheral is modelled, so they stay disabled
    wr(ADCC_OFS_ENABLE, 32'(ADCC_ENABLE_ON));
    for (int i = 0; i < 8; i++) begin
      cfg = 32'(i % 3) | (32'(inp_codes[i % 5]) << ADCC_INP_LSB) | (32'(i % 4) << ADCC_REF_LSB);
      cfg = cfg | (32'h1 << (ADCC_PSEL_LSB + i)) | (32'(i % 3) << ADCC_EXT_LSB);
      wr(ADCC_OFS_CONFIG, cfg);
      repeat (2) @(posedge clk);
      chk("resolution", 32'(resolution), 32'(i % 3));
      chk("input select", 32'(input_source_select), 32'(inp_codes[i % 5]));
      chk("reference", 32'(reference_select), 32'(i % 4));
      chk("pin claim", 32'(analog_pin_claim), 32'h1 << i);
      chk("ref pin claim", 32'(ref_pin_claim), (i % 4 == 1) ? 32'(i % 3) : 32'h0);
      rd(ADCC_OFS_CONFIG, 2'h0, cfg);
    end
    wr(ADCC_OFS_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("pin release", 32'(analog_pin_claim), 32'h0);
    $display("test configuration done");
    wr(ADCC_OFS_ENABLE, 32'(ADCC_ENABLE_ON));
    wr(ADCC_OFS_IRQ_SET, 32'h0000_0001);
    rd(ADCC_OFS_IRQ_SET, 2'h0, 32'h1);
    for (int r = 0; r < 3; r++) begin
      cfg = 32'(r) | 32'h0000_0100;
      wr(ADCC_OFS_CONFIG, cfg);
      level <= 10'($random(seed));
      go(r == 1);
      rd(ADCC_OFS_BUSY, 2'h0, 32'h1);
      chk("power on", 32'(analog_power_req), 32'h1);
      wr(ADCC_OFS_CONFIG, 32'h0000_0002);
      wait_done();
      exp_res = 32'(level) >> (2 - r);
      repeat (2) @(posedge clk);
      chk("power off", 32'(analog_power_req), 32'h0);
      chk("irq set", 32'(irq), 32'h1);
      rd(ADCC_OFS_RESULT, 2'h0, exp_res);
      rd(ADCC_OFS_DONE, 2'h0, 32'h1);
      rd(ADCC_OFS_CONFIG, 2'h0, cfg);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'(irq), 32'h0);
      idle(250);
      chk("no restart", 32'(dn), 32'h0);
      rd(ADCC_OFS_BUSY, 2'h0, 32'h0);
    end
    $display("test conversions done");
    wr(ADCC_OFS_IRQ_CLR, 32'h0000_0001);
    rd(ADCC_OFS_IRQ_SET, 2'h0, 32'h0);
    go(1'b0);
    wait_done();
    repeat (2) @(posedge clk);
    chk("irq masked", 32'(irq), 32'h0);
    rd(ADCC_OFS_DONE, 2'h0, 32'h1);
    $display("test interrupt mask done");
    level <= ~level;
    go(1'b1);
    repeat (20) @(posedge clk);
    wr(ADCC_OFS_STOP, 32'h0000_0001);
    idle(250);
    chk("stop no done", 32'(dn), 32'h0);
    chk("stop power", 32'(analog_power_req), 32'h0);
    rd(ADCC_OFS_BUSY, 2'h0, 32'h0);
    rd(ADCC_OFS_RESULT, 2'h0, exp_res);
    rd(ADCC_OFS_DONE, 2'h0, 32'h0);
    $display("test stop done");
    conclude();
  end
endmodule
